// *** src/epu_defines.vh ***
// Constants for the panel update and plane memory command block
// Behaviour
// [RQ1] Command 22h takes one parameter byte choosing the update stages, which is FFh after reset.
// [RQ2] Stage byte C7h runs clock on, analog on, panel drive, analog off, then clock source off.
// [RQ3] Stage byte 91h runs clock on, waveform table load, then clock source off, with no panel drive.
// [RQ4] After command 24h every data byte goes to the mono plane memory with the pointer advancing, until a new command.
// [RQ5] The host writes 1 for a white pixel and 0 for a black pixel into the mono plane.
// [RQ6] After command 26h every data byte goes to the red plane memory with the pointer advancing, until a new command.
// [RQ7] The host writes 1 for a red pixel and 0 for a black or white pixel into the red plane.
// [RQ8] Command 2Ch takes one parameter byte into the common electrode level, which is 00h after reset.
// [RQ9] The level byte is a table code for a negative voltage in 0.1 V steps, 08h for -0.2 V up to 6Fh for -2.8 V.
// [RQ10] Command 20h starts the update sequence with the stages chosen by the stage byte.
// [RQ11] Busy stays high for the whole update sequence and the host sends nothing that interrupts it meanwhile.
// [RQ12] The select line is low for a command byte and high for a parameter or pixel byte, and bytes are decoded so.
`ifndef EPU_DEFINES_VH
`define EPU_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define EPU_CMD_ACTIVATE 8'h20
`define EPU_CMD_STAGE 8'h22
`define EPU_CMD_WR_MONO 8'h24
`define EPU_CMD_WR_RED 8'h26
`define EPU_CMD_LEVEL 8'h2C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPU_STAGE_RST 8'hFF
`define EPU_LEVEL_RST 8'h00

// ----------------------------------------
// Stage byte bit positions
// ----------------------------------------
`define EPU_STG_CLK_ON 3'd7
`define EPU_STG_ANA_ON 3'd6
`define EPU_STG_LOAD 3'd4
`define EPU_STG_DRIVE 3'd2
`define EPU_STG_ANA_OFF 3'd1
`define EPU_STG_OSC_OFF 3'd0

// ----------------------------------------
// Stage durations in clk cycles
// ----------------------------------------
`define EPU_STEP_CYCLES 16
`define EPU_LOAD_CYCLES 32
`define EPU_DRIVE_CYCLES 64

// ----------------------------------------
// Plane geometry
// ----------------------------------------
`define EPU_PLANE_BYTES 2756
`define EPU_PLANE_AW 12

`endif

// *** src/epu_fifo.v ***
// Small valid/ready FIFO between the serial receiver and the decoder
`timescale 1ns/1ps
module epu_fifo #(
   parameter W = 9,
   parameter D = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   localparam [AW:0] FULL = D[AW:0];
   localparam [AW-1:0] LAST = D[AW-1:0] - 1'b1;
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wptr_ff;
   reg [AW-1:0] rptr_ff;
   reg [AW:0] count_ff;
   wire push;
   wire pop;

   assign in_ready = (count_ff != FULL);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data = mem[rptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wptr_ff] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         wptr_ff <= {AW{1'b0}};
         rptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wptr_ff <= (wptr_ff == LAST) ? {AW{1'b0}} : wptr_ff + 1'b1;
         end
         if (pop) begin
            rptr_ff <= (rptr_ff == LAST) ? {AW{1'b0}} : rptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule // epu_fifo

// *** src/epu_core.v ***
// Serial command receiver, update sequencer and plane memories
`timescale 1ns/1ps
`include "epu_defines.vh"
module epu_core #(
   parameter MEM_DEPTH = `EPU_PLANE_BYTES,
   parameter AW = `EPU_PLANE_AW,
   parameter STEP_CYCLES = `EPU_STEP_CYCLES,
   parameter LOAD_CYCLES = `EPU_LOAD_CYCLES,
   parameter DRIVE_CYCLES = `EPU_DRIVE_CYCLES,
   parameter FIFO_DEPTH = 4
) (
   input wire clk,
   input wire rst,
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_sdin,
   input wire spi_dc,
   output wire rx_ready,
   output wire rx_drop,
   output wire busy,
   output wire internal_clock_source_en,
   output wire analog_en,
   output wire waveform_table_load,
   output wire panel_drive,
   output wire [7:0] update_stage_select,
   output wire [7:0] common_electrode_level,
   output wire [4:0] level_tenths,
   output wire level_valid,
   input wire rd_plane,
   input wire [AW-1:0] rd_addr,
   output wire [7:0] rd_data
);
   // ----------------------------------------
   // Local constants
   // ----------------------------------------
   localparam [2:0] M_IDLE = 3'd0;
   localparam [2:0] M_STAGE = 3'd1;
   localparam [2:0] M_LEVEL = 3'd2;
   localparam [2:0] M_MONO = 3'd3;
   localparam [2:0] M_RED = 3'd4;
   localparam SQ_IDLE = 1'b0;
   localparam SQ_RUN = 1'b1;
   localparam [2:0] STG_LAST = 3'd5;
   localparam [AW-1:0] PTR_LAST = MEM_DEPTH[AW-1:0] - 1'b1;
   localparam [15:0] STEP_N = STEP_CYCLES[15:0] - 16'd1;
   localparam [15:0] LOAD_N = LOAD_CYCLES[15:0] - 16'd1;
   localparam [15:0] DRIVE_N = DRIVE_CYCLES[15:0] - 16'd1;

   // Stage order in the sequence, mapped to its bit of the stage byte
   function [2:0] stage_bit;
      input [2:0] idx;
      begin
         case (idx)
            3'd0: stage_bit = `EPU_STG_CLK_ON;
            3'd1: stage_bit = `EPU_STG_ANA_ON;
            3'd2: stage_bit = `EPU_STG_LOAD;
            3'd3: stage_bit = `EPU_STG_DRIVE;
            3'd4: stage_bit = `EPU_STG_ANA_OFF;
            default: stage_bit = `EPU_STG_OSC_OFF;
         endcase
      end
   endfunction

   // Level code to tenths of a volt, bit 5 flags a tabulated code
   function [5:0] level_decode;
      input [7:0] code;
      begin
         case (code)
            8'h08: level_decode = {1'b1, 5'd2};
            8'h0B: level_decode = {1'b1, 5'd3};
            8'h10: level_decode = {1'b1, 5'd4};
            8'h14: level_decode = {1'b1, 5'd5};
            8'h17: level_decode = {1'b1, 5'd6};
            8'h1B: level_decode = {1'b1, 5'd7};
            8'h20: level_decode = {1'b1, 5'd8};
            8'h24: level_decode = {1'b1, 5'd9};
            8'h28: level_decode = {1'b1, 5'd10};
            8'h2C: level_decode = {1'b1, 5'd11};
            8'h2F: level_decode = {1'b1, 5'd12};
            8'h34: level_decode = {1'b1, 5'd13};
            8'h37: level_decode = {1'b1, 5'd14};
            8'h3C: level_decode = {1'b1, 5'd15};
            8'h40: level_decode = {1'b1, 5'd16};
            8'h44: level_decode = {1'b1, 5'd17};
            8'h48: level_decode = {1'b1, 5'd18};
            8'h4B: level_decode = {1'b1, 5'd19};
            8'h50: level_decode = {1'b1, 5'd20};
            8'h54: level_decode = {1'b1, 5'd21};
            8'h58: level_decode = {1'b1, 5'd22};
            8'h5B: level_decode = {1'b1, 5'd23};
            8'h5F: level_decode = {1'b1, 5'd24};
            8'h64: level_decode = {1'b1, 5'd25};
            8'h68: level_decode = {1'b1, 5'd26};
            8'h6C: level_decode = {1'b1, 5'd27};
            8'h6F: level_decode = {1'b1, 5'd28};
            default: level_decode = 6'h00;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers and byte receiver
   // ----------------------------------------
   reg [3:0] sync1_ff;
   reg [3:0] sync2_ff;
   reg sclk_d_ff;
   reg [6:0] shift_ff;
   reg [2:0] bitcnt_ff;
   reg push_ff;
   reg [8:0] push_data_ff;
   wire sclk_s = sync2_ff[0];
   wire cs_n_s = sync2_ff[1];
   wire sdin_s = sync2_ff[2];
   wire dc_s = sync2_ff[3];
   wire sclk_rise = sclk_s & ~sclk_d_ff;

   always @(posedge clk) begin
      if (rst) begin
         sync1_ff <= 4'h2;
         sync2_ff <= 4'h2;
         sclk_d_ff <= 1'b0;
         shift_ff <= 7'h00;
         bitcnt_ff <= 3'd0;
         push_ff <= 1'b0;
         push_data_ff <= 9'h000;
      end else begin
         sync1_ff <= {spi_dc, spi_sdin, spi_cs_n, spi_sclk};
         sync2_ff <= sync1_ff;
         sclk_d_ff <= sclk_s;
         push_ff <= 1'b0;
         if (cs_n_s) begin
            bitcnt_ff <= 3'd0;
         end else if (sclk_rise) begin
            shift_ff <= {shift_ff[5:0], sdin_s};
            bitcnt_ff <= bitcnt_ff + 3'd1;
            if (bitcnt_ff == 3'd7) begin
               // Select level taken with the last bit of the byte
               push_ff <= 1'b1; // [RQ12]
               push_data_ff <= {dc_s, shift_ff, sdin_s};
            end
         end
      end
   end

   // ----------------------------------------
   // Byte FIFO
   // ----------------------------------------
   wire fifo_valid;
   wire fifo_in_ready;
   wire [8:0] fifo_data;
   wire take;
   reg seq_ff;

   // Decoder stalls while the sequence runs, so bytes queue up behind it
   assign take = fifo_valid & (seq_ff == SQ_IDLE); // [RQ11]
   assign rx_ready = fifo_in_ready;
   // Serial link cannot be stalled; a byte arriving on a full FIFO is lost
   assign rx_drop = push_ff & ~fifo_in_ready;

   epu_fifo #(.W(9), .D(FIFO_DEPTH), .AW(2)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(push_ff),
      .in_ready(fifo_in_ready),
      .in_data(push_data_ff),
      .out_valid(fifo_valid),
      .out_ready(take),
      .out_data(fifo_data)
   );

   // ----------------------------------------
   // Command decoder and plane memories
   // ----------------------------------------
   reg [7:0] mono_plane_memory [0:MEM_DEPTH-1];
   reg [7:0] red_plane_memory [0:MEM_DEPTH-1];
   reg [2:0] mode_ff;
   reg [AW-1:0] ptr_ff;
   reg [7:0] stage_ff;
   reg [7:0] level_ff;
   reg [5:0] level_dec_ff;
   reg start_ff;
   reg [7:0] rd_data_ff;
   wire is_data = fifo_data[8];
   wire [7:0] byte_v = fifo_data[7:0];
   wire mono_wr = take & is_data & (mode_ff == M_MONO);
   wire red_wr = take & is_data & (mode_ff == M_RED);

   always @(posedge clk) begin
      // Pixel bits stored as sent: mono 1 white 0 black, red 1 red 0 other
      if (mono_wr) begin
         mono_plane_memory[ptr_ff] <= byte_v; // [RQ4] [RQ5]
      end
      if (red_wr) begin
         red_plane_memory[ptr_ff] <= byte_v; // [RQ6] [RQ7]
      end
      rd_data_ff <= rd_plane ? red_plane_memory[rd_addr] : mono_plane_memory[rd_addr];
   end

   always @(posedge clk) begin
      if (rst) begin
         mode_ff <= M_IDLE;
         ptr_ff <= {AW{1'b0}};
         stage_ff <= `EPU_STAGE_RST; // [RQ1]
         level_ff <= `EPU_LEVEL_RST; // [RQ8]
         level_dec_ff <= 6'h00;
         start_ff <= 1'b0;
      end else begin
         start_ff <= 1'b0;
         level_dec_ff <= level_decode(level_ff); // [RQ9]
         if (take && !is_data) begin
            ptr_ff <= {AW{1'b0}};
            case (byte_v) // [RQ12]
               `EPU_CMD_STAGE: mode_ff <= M_STAGE;
               `EPU_CMD_LEVEL: mode_ff <= M_LEVEL;
               `EPU_CMD_WR_MONO: mode_ff <= M_MONO; // [RQ4]
               `EPU_CMD_WR_RED: mode_ff <= M_RED; // [RQ6]
               `EPU_CMD_ACTIVATE: begin
                  mode_ff <= M_IDLE;
                  start_ff <= 1'b1; // [RQ10]
               end
               default: mode_ff <= M_IDLE;
            endcase
         end else if (take) begin
            case (mode_ff)
               M_STAGE: begin
                  stage_ff <= byte_v; // [RQ1]
                  mode_ff <= M_IDLE;
               end
               M_LEVEL: begin
                  level_ff <= byte_v; // [RQ8]
                  mode_ff <= M_IDLE;
               end
               M_MONO, M_RED: begin
                  ptr_ff <= (ptr_ff == PTR_LAST) ? {AW{1'b0}} : ptr_ff + 1'b1; // [RQ4] [RQ6]
               end
               default: mode_ff <= M_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Update sequencer
   // ----------------------------------------
   reg [2:0] idx_ff;
   reg [15:0] cnt_ff;
   reg clk_en_ff;
   reg ana_en_ff;
   reg [2:0] cur_bit;
   reg [15:0] cur_len;
   wire cur_on = stage_ff[cur_bit];

   always @* begin
      cur_bit = stage_bit(idx_ff);
      if (cur_bit == `EPU_STG_LOAD) begin
         cur_len = LOAD_N;
      end else if (cur_bit == `EPU_STG_DRIVE) begin
         cur_len = DRIVE_N;
      end else begin
         cur_len = STEP_N;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         seq_ff <= SQ_IDLE;
         idx_ff <= 3'd0;
         cnt_ff <= 16'h0000;
         clk_en_ff <= 1'b0;
         ana_en_ff <= 1'b0;
      end else begin
         case (seq_ff)
            SQ_IDLE: begin
               if (start_ff) begin
                  seq_ff <= SQ_RUN; // [RQ10] [RQ11]
                  idx_ff <= 3'd0;
                  cnt_ff <= 16'h0000;
               end
            end
            SQ_RUN: begin
               // Disabled stages are skipped in one cycle, in fixed order
               if (!cur_on || cnt_ff == cur_len) begin // [RQ2] [RQ3]
                  cnt_ff <= 16'h0000;
                  if (cur_on && cur_bit == `EPU_STG_CLK_ON) begin
                     clk_en_ff <= 1'b1;
                  end
                  if (cur_on && cur_bit == `EPU_STG_ANA_ON) begin
                     ana_en_ff <= 1'b1;
                  end
                  if (cur_on && cur_bit == `EPU_STG_ANA_OFF) begin
                     ana_en_ff <= 1'b0;
                  end
                  if (cur_on && cur_bit == `EPU_STG_OSC_OFF) begin
                     clk_en_ff <= 1'b0;
                  end
                  if (idx_ff == STG_LAST) begin
                     seq_ff <= SQ_IDLE;
                  end else begin
                     idx_ff <= idx_ff + 3'd1;
                  end
               end else begin
                  cnt_ff <= cnt_ff + 16'h0001;
               end
            end
            default: seq_ff <= SQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign busy = (seq_ff == SQ_RUN); // [RQ11]
   assign internal_clock_source_en = clk_en_ff;
   assign analog_en = ana_en_ff;
   assign waveform_table_load = busy & cur_on & (cur_bit == `EPU_STG_LOAD); // [RQ3]
   assign panel_drive = busy & cur_on & (cur_bit == `EPU_STG_DRIVE); // [RQ2]
   assign update_stage_select = stage_ff;
   assign common_electrode_level = level_ff;
   assign level_tenths = level_dec_ff[4:0];
   assign level_valid = level_dec_ff[5];
   assign rd_data = rd_data_ff;
endmodule // epu_core

// *** dv/epu_core_sva.sv ***
// Assertion checker for the update and plane memory command block
`timescale 1ns/1ps
module epu_core_sva #(
   parameter LOAD_CYCLES = 32,
   parameter DRIVE_CYCLES = 64
) (
   input wire clk,
   input wire rst,
   input wire busy,
   input wire internal_clock_source_en,
   input wire analog_en,
   input wire waveform_table_load,
   input wire panel_drive,
   input wire [7:0] update_stage_select,
   input wire [7:0] common_electrode_level,
   input wire [4:0] level_tenths,
   input wire level_valid
);
   reg [11:0] drv_cnt_ff;
   reg [11:0] ld_cnt_ff;
   wire [11:0] nxt_drv_cnt = panel_drive ? drv_cnt_ff + 12'h001 : 12'h000;
   wire [11:0] nxt_ld_cnt = waveform_table_load ? ld_cnt_ff + 12'h001 : 12'h000;
   always @(posedge clk) begin
      drv_cnt_ff <= rst ? 12'h000 : nxt_drv_cnt;
      ld_cnt_ff <= rst ? 12'h000 : nxt_ld_cnt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_stage_rst: assert property ($fell(rst) |-> update_stage_select == 8'hFF && !busy)
      else $error("stage byte not at its reset value");
   chk_level_rst: assert property ($fell(rst) |-> common_electrode_level == 8'h00 && !level_valid)
      else $error("level byte not at its reset value");
   chk_level_low: assert property (common_electrode_level == 8'h08 ##1 common_electrode_level == 8'h08
      |-> level_valid && level_tenths == 5'd2)
      else $error("code 08 not decoded as 0.2 V");
   chk_level_high: assert property (common_electrode_level == 8'h6F ##1 common_electrode_level == 8'h6F
      |-> level_valid && level_tenths == 5'd28)
      else $error("code 6F not decoded as 2.8 V");
   chk_level_bad: assert property (common_electrode_level == 8'h00 ##1 common_electrode_level == 8'h00
      |-> !level_valid && level_tenths == 5'd0)
      else $error("untabulated code reported valid");
   chk_drive_ctx: assert property (panel_drive |-> busy && analog_en && internal_clock_source_en)
      else $error("panel driven without clock, analog or busy");
   chk_load_ctx: assert property (waveform_table_load |-> busy && internal_clock_source_en && !panel_drive)
      else $error("table load outside a clocked busy stage");
   chk_drive_len: assert property ($fell(panel_drive) |-> drv_cnt_ff == DRIVE_CYCLES)
      else $error("drive stage length wrong");
   chk_load_len: assert property ($fell(waveform_table_load) |-> ld_cnt_ff == LOAD_CYCLES)
      else $error("load stage length wrong");
   chk_stage_hold: assert property (busy ##1 busy |-> $stable(update_stage_select))
      else $error("stage byte changed during update");
   chk_osc_off: assert property ($fell(busy) && update_stage_select[0] |-> !internal_clock_source_en)
      else $error("clock source left on after update");
endmodule // epu_core_sva

bind epu_core epu_core_sva #(.LOAD_CYCLES(LOAD_CYCLES), .DRIVE_CYCLES(DRIVE_CYCLES)) u_sva (
   .clk(clk),
   .rst(rst),
   .busy(busy),
   .internal_clock_source_en(internal_clock_source_en),
   .analog_en(analog_en),
   .waveform_table_load(waveform_table_load),
   .panel_drive(panel_drive),
   .update_stage_select(update_stage_select),
   .common_electrode_level(common_electrode_level),
   .level_tenths(level_tenths),
   .level_valid(level_valid)
);

// *** dv/epu_host_model.sv ***
// Host controller model driving the serial command link
`timescale 1ns/1ps
module epu_host_model (
   input wire clk,
   output reg spi_sclk,
   output reg spi_cs_n,
   output reg spi_sdin,
   output reg spi_dc
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdin = 1'b0;
      spi_dc = 1'b0;
   end
   // Offset from clk edges so sampling never races the change
   task send(input dc, input [7:0] b);
      integer k;
      begin
         // Chip select idles high for over 3 clk so the receiver sees the gap
         repeat (4) @(negedge clk);
         #1.25;
         spi_cs_n = 1'b0;
         spi_dc = dc;
         for (k = 7; k >= 0; k = k - 1) begin
            spi_sdin = b[k];
            #62.5 spi_sclk = 1'b1;
            #62.5 spi_sclk = 1'b0;
         end
         #62.5 spi_cs_n = 1'b1;
         // Released lines must not keep a stale value
         spi_sdin = ~b[0];
         spi_dc = ~dc;
      end
   endtask
endmodule // epu_host_model

// *** dv/epu_core_tb_top.sv ***
// Self-checking bench for the update and plane memory command block
`timescale 1ns/1ps
module epu_core_tb_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg rd_plane = 1'b0;
   reg [11:0] rd_addr = 12'h000;
   wire spi_sclk, spi_cs_n, spi_sdin, spi_dc, rx_ready, rx_drop, busy, clk_en, analog_en, wt_load, panel_drive;
   wire level_valid;
   wire [7:0] stage, level, rd_data;
   wire [4:0] level_tenths;
   integer num_errors = 0, n_tests = 0, drv_n, ld_n, drops, i, k;
   reg ana_seen, full_seen;
   always #5 clk = ~clk;
   epu_host_model host (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdin(spi_sdin), .spi_dc(spi_dc));
   epu_core #(.STEP_CYCLES(4), .LOAD_CYCLES(6), .DRIVE_CYCLES(800)) uut (
      .clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdin(spi_sdin), .spi_dc(spi_dc),
      .rx_ready(rx_ready), .rx_drop(rx_drop), .busy(busy), .internal_clock_source_en(clk_en),
      .analog_en(analog_en), .waveform_table_load(wt_load), .panel_drive(panel_drive),
      .update_stage_select(stage), .common_electrode_level(level), .level_tenths(level_tenths),
      .level_valid(level_valid), .rd_plane(rd_plane), .rd_addr(rd_addr), .rd_data(rd_data));
   // ----------------------------------------
   // Monitor
   // ----------------------------------------
   always @(posedge clk) begin
      if (panel_drive === 1'b1) drv_n <= drv_n + 1;
      if (wt_load === 1'b1) ld_n <= ld_n + 1;
      if (rx_drop === 1'b1) drops <= drops + 1;
      if (analog_en === 1'b1) ana_seen <= 1'b1;
      if (rx_ready === 1'b0) full_seen <= 1'b1;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task give_verdict;
      begin
         if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task check(input [8*8-1:0] what, input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task clr_mon;
      begin
         drv_n = 0;
         ld_n = 0;
         drops = 0;
         ana_seen = 1'b0;
         full_seen = 1'b0;
      end
   endtask
   task wait_busy(input v);
      begin
         k = 0;
         while (busy !== v && k < 3000) begin
            @(negedge clk);
            k = k + 1;
         end
         if (busy !== v) begin
            num_errors = num_errors + 1;
            give_verdict;
         end
      end
   endtask
   task rd(input p, input [11:0] a, input [7:0] exp);
      begin
         @(negedge clk);
         rd_plane = p;
         rd_addr = a;
         @(negedge clk);
         check("rd_data", rd_data, exp);
      end
   endtask
   task update(input [7:0] sel);
      begin
         host.send(1'b0, 8'h22);
         host.send(1'b1, sel);
         // Cleared before activation so no stage can slip past the counters
         clr_mon;
         host.send(1'b0, 8'h20);
         wait_busy(1'b1);
      end
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      clr_mon;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check("stage", stage, 8'hFF);
      check("level", level, 8'h00);
      check("enables", {busy, clk_en, analog_en, wt_load, panel_drive}, 5'h00);
      for (i = 0; i < 4; i = i + 1) begin
         host.send(1'b0, 8'h2C);
         host.send(1'b1, 32'h086F_1473 >> (24 - 8 * i));
         repeat (12) @(negedge clk);
         check("level", level, (32'h086F_1473 >> (24 - 8 * i)) & 32'h0000_00FF);
         check("decoded", {level_valid, level_tenths}, (32'h223C_2500 >> (24 - 8 * i)) & 32'h0000_00FF);
      end
      // Byte sent with select low is a command, not the parameter
      host.send(1'b0, 8'h2C);
      host.send(1'b0, 8'h08);
      host.send(1'b1, 8'h14);
      repeat (12) @(negedge clk);
      check("level", level, 8'h73);
      host.send(1'b0, 8'h24);
      host.send(1'b1, 8'hA5);
      host.send(1'b1, 8'h3C);
      host.send(1'b0, 8'h26);
      host.send(1'b1, 8'h81);
      host.send(1'b1, 8'h7E);
      host.send(1'b0, 8'h24);
      host.send(1'b1, 8'hF0);
      host.send(1'b0, 8'h2C);
      repeat (12) @(negedge clk);
      rd(1'b0, 12'h000, 8'hF0);
      rd(1'b0, 12'h001, 8'h3C);
      rd(1'b1, 12'h000, 8'h81);
      rd(1'b1, 12'h001, 8'h7E);
      host.send(1'b1, 8'h6F);
      update(8'hC7);
      // Data bytes queue behind the busy decoder until the buffer refuses
      for (i = 0; i < 5; i = i + 1) host.send(1'b1, 8'h55);
      check("full", {full_seen, drops[3:0]}, 5'h11);
      wait_busy(1'b0);
      repeat (60) @(negedge clk);
      check("stage", stage, 8'hC7);
      check("drive_n", drv_n, 16'h0320);
      check("c7_seq", {ana_seen, ld_n[7:0], analog_en, clk_en}, 11'h400);
      check("ready", rx_ready, 1'b1);
      check("level", level, 8'h6F);
      update(8'h91);
      wait_busy(1'b0);
      repeat (4) @(negedge clk);
      check("load_n", ld_n, 16'h0006);
      check("91_seq", {ana_seen, drv_n[7:0], clk_en}, 10'h000);
      // Reset after the update has finished brings both bytes back to their reset values
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      check("stage", stage, 8'hFF);
      check("level", level, 8'h00);
      give_verdict;
   end
endmodule // epu_core_tb_top
